// file: verilog/fpve_top.sv
`timescale 1ns/1ns
// What this block does
// - step-up or step-down adds or removes one unit of the pointed digit.
// - on the least significant digit each step is five units.
// - left pointer key moves toward msd, right key toward lsd.
// - held step and pointer keys auto-repeat their action.
// - a pointer key press briefly flashes a segment of the digit.
// - shifted visibility key toggles continuous flashing; function keys clear it.
// - sign key inverts polarity; stepping through zero flips polarity.
// - stepping saturates at range limits; range changes always allowed.
// - in step editing with output live, setpoint follows display at once.
// - no value editing in the resistance function.
// - first entry press enters keypad mode, lights led, pointer on msd.
// - digit on msd loads it and clears others; each digit above the lsd advances pointer.
// - lsd keyed 0 to 4 stores 0, 5 to 9 stores 5.
// - second entry press commits to setpoint; before that output unchanged.
// - shifted abort leaves keypad mode and restores the earlier value.
// - function key in keypad mode aborts and then selects that function.
// - range and sign keys work in keypad mode without leaving it.
// - output key toggles live and parked; parked drives zero or resistor.
// - in charge functions output stays live about one second per press.
// - null key toggles display to zero; zero sourced only when live.
// - any function key forces the output to parked.
module fpve_top
  import fpve_pkg::*;
#(
  parameter int WINDOW_CYCLES = WINDOW_CYC,
  parameter int REP_DELAY_CYCLES = REP_DELAY_CYC,
  parameter int REP_RATE_CYCLES = REP_RATE_CYC,
  parameter int FLASH_CYCLES = FLASH_CYC,
  parameter int BLINK_CYCLES = BLINK_CYC
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic step_up_i,
  input wire logic step_down_i,
  input wire logic ptr_left_i,
  input wire logic ptr_right_i,
  input wire logic cursor_vis_key_i,
  input wire logic sign_key_i,
  input wire logic entry_key_i,
  input wire logic abort_key_i,
  input wire logic digit_key_i,
  input wire logic [3:0] digit_val_i,
  input wire logic func_key_i,
  input wire logic [2:0] func_sel_i,
  input wire logic range_key_i,
  input wire logic [MAG_W-1:0] range_limit_i,
  input wire logic output_key_i,
  input wire logic null_key_i,
  output logic [MAG_W-1:0] disp_mag_o,
  output logic disp_neg_o,
  output logic [MAG_W-1:0] set_mag_o,
  output logic set_neg_o,
  output logic [PTR_W-1:0] pointer_o,
  output logic seg_flash_o,
  output logic keypad_led_o,
  output logic parked_o,
  output logic hi_res_o,
  output logic zero_charge_o,
  output logic null_o,
  output logic [2:0] func_o
);

  localparam logic [CNT_W-1:0] WINDOW_LAST = CNT_W'(WINDOW_CYCLES - 1);
  localparam logic [CNT_W-1:0] FLASH_LAST = CNT_W'(FLASH_CYCLES - 1);
  localparam logic [CNT_W-1:0] BLINK_LAST = CNT_W'(BLINK_CYCLES - 1);

  logic [NKEYS-1:0] press;
  logic [MAG_W-1:0] step_mag;
  logic step_neg;

  // editing state
  fpve_mode_t mode_reg, mode_next;
  fpve_func_t func_reg, func_next;
  logic [MAG_W-1:0] mag_reg, mag_next;
  logic neg_reg, neg_next;
  logic [MAG_W-1:0] save_mag_reg, save_mag_next;
  logic save_neg_reg, save_neg_next;
  logic [MAG_W-1:0] setp_mag_reg, setp_mag_next;
  logic setp_neg_reg, setp_neg_next;
  logic [MAG_W-1:0] limit_reg, limit_next;
  logic [PTR_W-1:0] ptr_reg, ptr_next;
  logic null_reg, null_next;
  logic keypad_reg, keypad_next;

  // output state
  fpve_out_t out_reg, out_next;
  logic [CNT_W-1:0] win_cnt_reg, win_cnt_next;
  logic parked_reg, parked_next;

  // pointer indication
  logic cursor_on_reg, cursor_on_next;
  logic [CNT_W-1:0] flash_cnt_reg, flash_cnt_next;
  logic flash_act_reg, flash_act_next;
  logic [CNT_W-1:0] blink_cnt_reg, blink_cnt_next;
  logic blink_reg, blink_next;

  // registered outputs
  logic [MAG_W-1:0] disp_mag_reg, disp_mag_next;
  logic disp_neg_reg, disp_neg_next;
  logic [MAG_W-1:0] set_mag_reg, set_mag_next;
  logic set_neg_reg, set_neg_next;
  logic flash_out_reg, flash_out_next;
  logic hi_res_reg, hi_res_next;
  logic zero_q_reg, zero_q_next;

  logic edit_ok;
  logic is_charge;
  logic [3:0] keyed;

  fpve_key_repeat #(
    .DELAY_CYC(REP_DELAY_CYCLES),
    .RATE_CYC(REP_RATE_CYCLES)
  ) u_repeat (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .keys_i({ptr_right_i, ptr_left_i, step_down_i, step_up_i}),
    .press_o(press)
  );

  fpve_step_calc u_step (
    .mag_i(mag_reg),
    .neg_i(neg_reg),
    .ptr_i(ptr_reg),
    .up_i(press[KEY_UP]),
    .limit_i(limit_reg),
    .mag_o(step_mag),
    .neg_o(step_neg)
  );

  // value editing
  always_comb begin
    mode_next = mode_reg;
    func_next = func_reg;
    mag_next = mag_reg;
    neg_next = neg_reg;
    save_mag_next = save_mag_reg;
    save_neg_next = save_neg_reg;
    setp_mag_next = setp_mag_reg;
    setp_neg_next = setp_neg_reg;
    limit_next = limit_reg;
    ptr_next = ptr_reg;
    null_next = null_reg;
    edit_ok = (func_reg != FN_OHMS);
    keyed = digit_val_i;
    if (ptr_reg == PTR_LSD) begin
      keyed = (digit_val_i >= LSD_QUANT_MIN) ? LSD_QUANT_VAL : 4'h0;
    end
    if (range_key_i) begin
      limit_next = range_limit_i;
      if (mag_reg > range_limit_i) begin
        mag_next = range_limit_i;
      end
    end
    if (null_key_i) begin
      null_next = !null_reg;
    end
    if (func_key_i) begin
      func_next = fpve_func_t'(func_sel_i);
      if (mode_reg == MODE_KEYPAD) begin
        mode_next = MODE_ADJUST;
        mag_next = save_mag_reg;
        neg_next = save_neg_reg;
      end
    end else if (mode_reg == MODE_KEYPAD && abort_key_i) begin
      mode_next = MODE_ADJUST;
      mag_next = save_mag_reg;
      neg_next = save_neg_reg;
    end else if (entry_key_i && edit_ok) begin
      if (mode_reg == MODE_ADJUST) begin
        mode_next = MODE_KEYPAD;
        save_mag_next = mag_reg;
        save_neg_next = neg_reg;
        ptr_next = PTR_MSD;
      end else begin
        mode_next = MODE_ADJUST;
        setp_mag_next = mag_reg;
        setp_neg_next = neg_reg;
      end
    end else if (mode_reg == MODE_KEYPAD && digit_key_i) begin
      if (ptr_reg == PTR_MSD) begin
        mag_next = MAG_W'(keyed * fpve_pow10(PTR_MSD));
      end else begin
        mag_next = MAG_W'(mag_reg + keyed * fpve_pow10(ptr_reg));
      end
      if (mag_next > limit_next) begin
        mag_next = limit_next;
      end
      if (ptr_reg != PTR_LSD) begin
        ptr_next = ptr_reg - 1'b1;
      end
    end else if (sign_key_i && edit_ok) begin
      neg_next = !neg_reg;
    end else if (mode_reg == MODE_ADJUST && edit_ok &&
                 (press[KEY_UP] || press[KEY_DOWN])) begin
      mag_next = step_mag;
      neg_next = step_neg;
    end else if (press[KEY_LEFT] && ptr_reg != PTR_MSD) begin
      ptr_next = ptr_reg + 1'b1;
    end else if (press[KEY_RIGHT] && ptr_reg != PTR_LSD) begin
      ptr_next = ptr_reg - 1'b1;
    end
    if (mode_next == MODE_ADJUST && mode_reg == MODE_ADJUST) begin
      setp_mag_next = mag_next;
      setp_neg_next = neg_next;
    end
    keypad_next = (mode_next == MODE_KEYPAD);
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_reg <= MODE_ADJUST;
      func_reg <= FN_VOLTS;
      mag_reg <= RST_MAG;
      neg_reg <= 1'b0;
      save_mag_reg <= RST_MAG;
      save_neg_reg <= 1'b0;
      setp_mag_reg <= RST_MAG;
      setp_neg_reg <= 1'b0;
      limit_reg <= RST_LIMIT;
      ptr_reg <= PTR_LSD;
      null_reg <= 1'b0;
      keypad_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      func_reg <= func_next;
      mag_reg <= mag_next;
      neg_reg <= neg_next;
      save_mag_reg <= save_mag_next;
      save_neg_reg <= save_neg_next;
      setp_mag_reg <= setp_mag_next;
      setp_neg_reg <= setp_neg_next;
      limit_reg <= limit_next;
      ptr_reg <= ptr_next;
      null_reg <= null_next;
      keypad_reg <= keypad_next;
    end
  end

  // output live, parked and charge window
  always_comb begin
    out_next = out_reg;
    win_cnt_next = win_cnt_reg;
    is_charge = (func_reg == FN_CHARGE_FUNCTION) ||
                (func_reg == FN_PASSIVE_CHARGE_FUNCTION);
    case (out_reg)
      OUT_PARKED: begin
        if (output_key_i) begin
          win_cnt_next = '0;
          out_next = is_charge ? OUT_WINDOW : OUT_LIVE;
        end
      end
      OUT_LIVE: begin
        if (output_key_i) begin
          out_next = OUT_PARKED;
        end
      end
      OUT_WINDOW: begin
        // repeated output key while the window runs is ignored
        if (win_cnt_reg == WINDOW_LAST) begin
          out_next = OUT_PARKED;
        end else begin
          win_cnt_next = win_cnt_reg + 1'b1;
        end
      end
      default: out_next = OUT_PARKED;
    endcase
    if (func_key_i) begin
      out_next = OUT_PARKED;
    end
    parked_next = (out_next == OUT_PARKED);
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_reg <= OUT_PARKED;
      parked_reg <= 1'b1;
      win_cnt_reg <= '0;
    end else begin
      out_reg <= out_next;
      parked_reg <= parked_next;
      win_cnt_reg <= win_cnt_next;
    end
  end

  // pointer flashing
  always_comb begin
    cursor_on_next = cursor_on_reg;
    flash_cnt_next = flash_cnt_reg;
    flash_act_next = flash_act_reg;
    blink_next = blink_reg;
    blink_cnt_next = blink_cnt_reg + 1'b1;
    if (blink_cnt_reg == BLINK_LAST) begin
      blink_cnt_next = '0;
      blink_next = !blink_reg;
    end
    if (cursor_vis_key_i) begin
      cursor_on_next = !cursor_on_reg;
    end
    if (func_key_i) begin
      cursor_on_next = 1'b0;
    end
    if (press[KEY_LEFT] || press[KEY_RIGHT]) begin
      flash_act_next = 1'b1;
      flash_cnt_next = '0;
    end else if (flash_act_reg) begin
      if (flash_cnt_reg == FLASH_LAST) begin
        flash_act_next = 1'b0;
      end else begin
        flash_cnt_next = flash_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cursor_on_reg <= 1'b0;
      flash_cnt_reg <= '0;
      flash_act_reg <= 1'b0;
      blink_cnt_reg <= '0;
      blink_reg <= 1'b0;
    end else begin
      cursor_on_reg <= cursor_on_next;
      flash_cnt_reg <= flash_cnt_next;
      flash_act_reg <= flash_act_next;
      blink_cnt_reg <= blink_cnt_next;
      blink_reg <= blink_next;
    end
  end

  // registered outputs, one cycle behind state
  always_comb begin
    disp_mag_next = null_reg ? RST_MAG : mag_reg;
    disp_neg_next = null_reg ? 1'b0 : neg_reg;
    set_mag_next = null_reg ? RST_MAG : setp_mag_reg;
    set_neg_next = null_reg ? 1'b0 : setp_neg_reg;
    flash_out_next = blink_reg & (flash_act_reg | cursor_on_reg |
                     (mode_reg == MODE_KEYPAD));
    hi_res_next = (out_reg == OUT_PARKED) && !is_charge;
    zero_q_next = (out_reg == OUT_PARKED) && is_charge;
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      disp_mag_reg <= RST_MAG;
      disp_neg_reg <= 1'b0;
      set_mag_reg <= RST_MAG;
      set_neg_reg <= 1'b0;
      flash_out_reg <= 1'b0;
      hi_res_reg <= 1'b0;
      zero_q_reg <= 1'b0;
    end else begin
      disp_mag_reg <= disp_mag_next;
      disp_neg_reg <= disp_neg_next;
      set_mag_reg <= set_mag_next;
      set_neg_reg <= set_neg_next;
      flash_out_reg <= flash_out_next;
      hi_res_reg <= hi_res_next;
      zero_q_reg <= zero_q_next;
    end
  end

  assign disp_mag_o = disp_mag_reg;
  assign disp_neg_o = disp_neg_reg;
  assign set_mag_o = set_mag_reg;
  assign set_neg_o = set_neg_reg;
  assign pointer_o = ptr_reg;
  assign seg_flash_o = flash_out_reg;
  assign keypad_led_o = keypad_reg;
  assign parked_o = parked_reg;
  assign hi_res_o = hi_res_reg;
  assign zero_charge_o = zero_q_reg;
  assign null_o = null_reg;
  assign func_o = func_reg;

endmodule : fpve_top

// file: include/fpve_pkg.sv
package fpve_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;

  // display: six digits, magnitude held as a binary count of lsd units
  localparam int MAG_W = 20;
  localparam int PTR_W = 3;
  localparam logic [PTR_W-1:0] PTR_MSD = 3'h5;
  localparam logic [PTR_W-1:0] PTR_LSD = 3'h0;
  localparam logic [MAG_W-1:0] LSD_STEP = 20'h00005;
  localparam logic [3:0] LSD_QUANT_MIN = 4'h5;
  localparam logic [3:0] LSD_QUANT_VAL = 4'h5;

  // times in their own unit, counts derived from the clock rate
  localparam int WINDOW_MS = 1000;
  localparam int WINDOW_CYC = WINDOW_MS * CYC_PER_MS;
  localparam int REP_DELAY_MS = 500;
  localparam int REP_DELAY_CYC = REP_DELAY_MS * CYC_PER_MS;
  localparam int REP_RATE_MS = 100;
  localparam int REP_RATE_CYC = REP_RATE_MS * CYC_PER_MS;
  localparam int FLASH_MS = 300;
  localparam int FLASH_CYC = FLASH_MS * CYC_PER_MS;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = BLINK_MS * CYC_PER_MS;
  localparam int CNT_W = 28;

  // held keys with auto-repeat
  localparam int NKEYS = 4;
  localparam int KEY_UP = 0;
  localparam int KEY_DOWN = 1;
  localparam int KEY_LEFT = 2;
  localparam int KEY_RIGHT = 3;

  // values after reset
  localparam logic [MAG_W-1:0] RST_LIMIT = 20'h30D3F;
  localparam logic [MAG_W-1:0] RST_MAG = 20'h00000;

  typedef enum logic [2:0] {
    FN_OHMS,
    FN_VOLTS,
    FN_EXT,
    FN_AMPS,
    FN_PASSIVE_AMPS,
    FN_CHARGE_FUNCTION,
    FN_PASSIVE_CHARGE_FUNCTION
  } fpve_func_t;

  typedef enum logic {MODE_ADJUST, MODE_KEYPAD} fpve_mode_t;
  typedef enum logic [1:0] {OUT_PARKED, OUT_LIVE, OUT_WINDOW} fpve_out_t;

  function automatic logic [MAG_W-1:0] fpve_pow10(input logic [PTR_W-1:0] p);
    case (p)
      3'h0: fpve_pow10 = 20'h00001;
      3'h1: fpve_pow10 = 20'h0000A;
      3'h2: fpve_pow10 = 20'h00064;
      3'h3: fpve_pow10 = 20'h003E8;
      3'h4: fpve_pow10 = 20'h02710;
      3'h5: fpve_pow10 = 20'h186A0;
      default: fpve_pow10 = 20'h00000;
    endcase
  endfunction : fpve_pow10

endpackage : fpve_pkg

// file: verilog/fpve_step_calc.sv
`timescale 1ns/1ns
module fpve_step_calc
  import fpve_pkg::*;
(
  input wire logic [MAG_W-1:0] mag_i,
  input wire logic neg_i,
  input wire logic [PTR_W-1:0] ptr_i,
  input wire logic up_i,
  input wire logic [MAG_W-1:0] limit_i,
  output logic [MAG_W-1:0] mag_o,
  output logic neg_o
);

  logic [MAG_W-1:0] unit;
  logic signed [MAG_W+1:0] cur;
  logic signed [MAG_W+1:0] nxt;
  logic [MAG_W+1:0] absn;

  always_comb begin
    unit = (ptr_i == PTR_LSD) ? LSD_STEP : fpve_pow10(ptr_i);
    cur = neg_i ? -$signed({2'b00, mag_i}) : $signed({2'b00, mag_i});
    nxt = up_i ? cur + $signed({2'b00, unit}) : cur - $signed({2'b00, unit});
    absn = (nxt < 0) ? (MAG_W+2)'(-nxt) : (MAG_W+2)'(nxt);
    neg_o = (nxt < 0);
    if (absn > {2'b00, limit_i}) begin
      mag_o = limit_i;
    end else begin
      mag_o = absn[MAG_W-1:0];
    end
  end

endmodule : fpve_step_calc

// file: verilog/fpve_key_repeat.sv
`timescale 1ns/1ns
module fpve_key_repeat
  import fpve_pkg::*;
#(
  parameter int DELAY_CYC = REP_DELAY_CYC,
  parameter int RATE_CYC = REP_RATE_CYC
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [NKEYS-1:0] keys_i,
  output logic [NKEYS-1:0] press_o
);

  localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(DELAY_CYC - 1);
  localparam logic [CNT_W-1:0] RATE_LAST = CNT_W'(RATE_CYC - 1);

  genvar k;
  generate
    for (k = 0; k < NKEYS; k++) begin : g_key
      logic [CNT_W-1:0] cnt_reg, cnt_next;
      logic held_reg, held_next;
      logic rep_reg, rep_next;
      logic press_reg, press_next;

      always_comb begin
        cnt_next = cnt_reg;
        held_next = held_reg;
        rep_next = rep_reg;
        press_next = 1'b0;
        if (!keys_i[k]) begin
          cnt_next = '0;
          held_next = 1'b0;
          rep_next = 1'b0;
        end else if (!held_reg) begin
          held_next = 1'b1;
          press_next = 1'b1;
        end else if (cnt_reg == (rep_reg ? RATE_LAST : DELAY_LAST)) begin
          cnt_next = '0;
          rep_next = 1'b1;
          press_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end

      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          cnt_reg <= '0;
          held_reg <= 1'b0;
          rep_reg <= 1'b0;
          press_reg <= 1'b0;
        end else begin
          cnt_reg <= cnt_next;
          held_reg <= held_next;
          rep_reg <= rep_next;
          press_reg <= press_next;
        end
      end

      assign press_o[k] = press_reg;
    end
  endgenerate

endmodule : fpve_key_repeat

// file: tb/fpve_chk_sva.sv
`timescale 1ns/1ns
module fpve_chk
  import fpve_pkg::*;
#(
  parameter int WINDOW_CYCLES = WINDOW_CYC
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic entry_key_i,
  input wire logic abort_key_i,
  input wire logic func_key_i,
  input wire logic [2:0] func_sel_i,
  input wire logic range_key_i,
  input wire logic output_key_i,
  input wire logic null_key_i,
  input wire logic [MAG_W-1:0] disp_mag_o,
  input wire logic [MAG_W-1:0] set_mag_o,
  input wire logic [PTR_W-1:0] pointer_o,
  input wire logic keypad_led_o,
  input wire logic parked_o,
  input wire logic hi_res_o,
  input wire logic zero_charge_o,
  input wire logic null_o,
  input wire logic [2:0] func_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  logic charge_fn;
  logic [CNT_W-1:0] live_cnt_reg;
  logic [CNT_W-1:0] live_cnt_next;
  assign charge_fn = func_o >= 3'h5;
  // counts cycles of a live charge window
  always_comb begin
    live_cnt_next = (!parked_o && charge_fn) ? live_cnt_reg + 1'b1 : '0;
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) live_cnt_reg <= '0;
    else live_cnt_reg <= live_cnt_next;
  end
  sequence kp_quiet_s;
    (keypad_led_o && !range_key_i && !null_key_i)[*2] ##1 keypad_led_o;
  endsequence
  sequence std_park_s;
    (parked_o && !charge_fn)[*2];
  endsequence
  sequence chg_park_s;
    (parked_o && charge_fn)[*2];
  endsequence
  enter_keypad_a: assert property (
    entry_key_i && !keypad_led_o && func_o != FN_OHMS && !func_key_i
    |=> keypad_led_o && pointer_o == PTR_MSD) else $error("keypad entry");
  keypad_hold_a: assert property (kp_quiet_s |-> $stable(set_mag_o))
    else $error("setpoint moved in keypad");
  commit_a: assert property (
    keypad_led_o && entry_key_i && !func_key_i && !abort_key_i &&
    !range_key_i && !null_key_i
    |=> !keypad_led_o ##1 set_mag_o == disp_mag_o) else $error("commit");
  abort_exit_a: assert property (
    keypad_led_o && abort_key_i && !func_key_i |=> !keypad_led_o)
    else $error("abort");
  func_park_a: assert property (
    func_key_i && !output_key_i |=> parked_o && !keypad_led_o &&
    func_o == $past(func_sel_i)) else $error("function key");
  ptr_move_a: assert property ($changed(pointer_o) |->
    pointer_o == $past(pointer_o) + 3'h1 ||
    pointer_o == $past(pointer_o) - 3'h1 ||
    keypad_led_o != $past(keypad_led_o)) else $error("pointer jump");
  ptr_bound_a: assert property (pointer_o <= PTR_MSD)
    else $error("pointer range");
  ohms_fixed_a: assert property (
    (func_o == FN_OHMS && !range_key_i && !null_key_i)[*3]
    |-> $stable(disp_mag_o)) else $error("ohms value moved");
  park_res_a: assert property (std_park_s |-> hi_res_o && !zero_charge_o)
    else $error("parked resistor");
  park_chg_a: assert property (chg_park_s |-> zero_charge_o && !hi_res_o)
    else $error("parked charge");
  window_max_a: assert property (live_cnt_reg <= WINDOW_CYCLES)
    else $error("window too long");
  window_len_a: assert property (
    $rose(parked_o) && charge_fn && !$past(func_key_i)
    |-> live_cnt_reg == WINDOW_CYCLES) else $error("window length");
  null_flip_a: assert property (null_key_i |=> null_o != $past(null_o))
    else $error("null toggle");
endmodule : fpve_chk

bind fpve_top fpve_chk #(.WINDOW_CYCLES(WINDOW_CYCLES)) chk_i (.*);

// file: tb/fpve_operator.sv
`timescale 1ns/1ns
module fpve_operator
  import fpve_pkg::*;
(
  input wire logic clock_i,
  output logic [12:0] keys_o,
  output logic [3:0] digit_val_o,
  output logic [2:0] func_sel_o,
  output logic [MAG_W-1:0] range_limit_o
);
  initial begin
    keys_o = '0;
    digit_val_o = 4'h0;
    func_sel_o = 3'h1;
    range_limit_o = RST_LIMIT;
  end
  // key k held n cycles, its qualifiers taken from v
  task automatic tap(input int k, input int n, input logic [MAG_W-1:0] v);
    @(negedge clock_i);
    digit_val_o = v[3:0];
    func_sel_o = v[2:0];
    range_limit_o = v;
    keys_o[k] = 1'b1;
    repeat (n) @(negedge clock_i);
    keys_o[k] = 1'b0;
    // released qualifiers no longer show the old value
    digit_val_o = ~digit_val_o;
    func_sel_o = ~func_sel_o;
    range_limit_o = ~range_limit_o;
  endtask : tap
endmodule : fpve_operator

// file: tb/fpve_top_tb.sv
`timescale 1ns/1ns
module fpve_top_tb;
  import fpve_pkg::*;
  localparam int K_UP = 0, K_DN = 1, K_L = 2, K_R = 3, K_VIS = 4;
  localparam int K_SGN = 5, K_ENT = 6, K_ABT = 7, K_DIG = 8, K_FN = 9;
  localparam int K_RNG = 10, K_OUT = 11, K_NUL = 12;
  logic clock_i;
  logic arst_n_i;
  logic [12:0] keys;
  logic [3:0] dval;
  logic [2:0] fsel, func;
  logic [MAG_W-1:0] rlim, disp_mag, set_mag, m_mag, m_lim, pre, val;
  logic disp_neg, set_neg, seg_flash, keypad_led, parked, hi_res, zchg;
  logic null_on, m_neg, up;
  logic [PTR_W-1:0] pointer, m_ptr;
  int err_total, n_tests;
  fpve_operator op (.clock_i(clock_i), .keys_o(keys), .digit_val_o(dval),
    .func_sel_o(fsel), .range_limit_o(rlim));
  fpve_top #(.WINDOW_CYCLES(50), .REP_DELAY_CYCLES(20),
    .REP_RATE_CYCLES(8), .FLASH_CYCLES(10), .BLINK_CYCLES(4)) dut (
    .clock_i(clock_i), .arst_n_i(arst_n_i),
    .step_up_i(keys[K_UP]), .step_down_i(keys[K_DN]),
    .ptr_left_i(keys[K_L]), .ptr_right_i(keys[K_R]),
    .cursor_vis_key_i(keys[K_VIS]), .sign_key_i(keys[K_SGN]),
    .entry_key_i(keys[K_ENT]), .abort_key_i(keys[K_ABT]),
    .digit_key_i(keys[K_DIG]), .digit_val_i(dval),
    .func_key_i(keys[K_FN]), .func_sel_i(fsel),
    .range_key_i(keys[K_RNG]), .range_limit_i(rlim),
    .output_key_i(keys[K_OUT]), .null_key_i(keys[K_NUL]),
    .disp_mag_o(disp_mag), .disp_neg_o(disp_neg), .set_mag_o(set_mag),
    .set_neg_o(set_neg), .pointer_o(pointer), .seg_flash_o(seg_flash),
    .keypad_led_o(keypad_led), .parked_o(parked), .hi_res_o(hi_res),
    .zero_charge_o(zchg), .null_o(null_on), .func_o(func));
  function automatic logic [20:0] step_ref(logic [19:0] m, logic n,
      logic [2:0] p, logic u_dir, logic [19:0] lim);
    int v;
    int u;
    u = (p == 3'h0) ? 5 : 10 ** p;
    v = n ? -int'(m) : int'(m);
    v = u_dir ? v + u : v - u;
    if (v > int'(lim)) v = lim;
    if (v < -int'(lim)) v = -int'(lim);
    return {v < 0, 20'(v < 0 ? -v : v)};
  endfunction : step_ref
  task automatic chk(string nm, logic [MAG_W-1:0] e, logic [MAG_W-1:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic act(int k, int n, logic [MAG_W-1:0] v);
    op.tap(k, n, v);
    repeat (6) @(negedge clock_i);
  endtask : act
  task automatic blinks(int n, output int c);
    logic last;
    c = 0;
    last = seg_flash;
    repeat (n) begin
      @(negedge clock_i);
      if (seg_flash !== last) c++;
      last = seg_flash;
    end
  endtask : blinks
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    $display("MISMATCH watchdog expected end seen hang");
    tally_and_finish();
  end
  initial begin
    int d;
    int tg;
    err_total = 0;
    n_tests = 0;
    arst_n_i = 1'b0;
    m_mag = '0;
    m_neg = 1'b0;
    m_ptr = '0;
    m_lim = RST_LIMIT;
    d = $urandom(19241);
    repeat (16) @(negedge clock_i);
    arst_n_i = 1'b1;
    repeat (3) @(negedge clock_i);
    chk("parked", 1, parked);
    chk("hi_res", 1, hi_res);
    chk("keypad", 0, keypad_led);
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      if (i == 8 || i == 16) begin
        m_lim = (i == 8) ? 20'h00064 : RST_LIMIT;
        act(K_RNG, 1, m_lim);
        if (m_mag > m_lim) m_mag = m_lim;
      end
      tg = $urandom % 6;
      while (int'(m_ptr) != tg) begin
        up = int'(m_ptr) < tg;
        act(up ? K_L : K_R, 1, 0);
        m_ptr = up ? m_ptr + 3'h1 : m_ptr - 3'h1;
      end
      chk("pointer", m_ptr, pointer);
      up = $urandom % 2;
      act(up ? K_UP : K_DN, 1, 0);
      {m_neg, m_mag} = step_ref(m_mag, m_neg, m_ptr, up, m_lim);
      chk("disp", m_mag, disp_mag);
      chk("setpoint", m_mag, set_mag);
      if (m_mag != 0) chk("sign", m_neg, disp_neg);
    end
    act(K_SGN, 1, 0);
    m_neg = ~m_neg;
    if (m_mag != 0) chk("sign key", m_neg, disp_neg);
    $display("test adjust done");
    act(K_L, 48, 0);
    act(K_R, 40, 0);
    m_ptr = 3'h1;
    chk("held pointer", m_ptr, pointer);
    act(K_UP, 34, 0);
    repeat (3) {m_neg, m_mag} = step_ref(m_mag, m_neg, m_ptr, 1, m_lim);
    chk("held step", m_mag, disp_mag);
    $display("test repeat done");
    for (int k = 0; k < 2; k++) begin
      pre = m_mag;
      val = '0;
      act(K_ENT, 1, 0);
      chk("keypad on", 1, keypad_led);
      chk("msd", PTR_MSD, pointer);
      if (k == 1) begin
        act(K_SGN, 1, 0);
        m_neg = ~m_neg;
        chk("keypad kept", 1, keypad_led);
      end
      for (int p = 5; p >= 0; p--) begin
        d = (p == 5) ? $urandom % 2 : (p > 0) ? $urandom % 10 : 4 + k * 5;
        act(K_DIG, 1, d);
        val = val + 20'((p > 0 ? d : (d >= 5 ? 5 : 0)) * 10 ** p);
        chk("keyed", val, disp_mag);
        chk("ptr", (p > 0) ? p - 1 : 0, pointer);
      end
      chk("held out", pre, set_mag);
      act(K_ENT, 1, 0);
      chk("keypad off", 0, keypad_led);
      chk("committed", val, set_mag);
      if (val != 0) chk("committed sign", m_neg, set_neg);
      m_mag = val;
    end
    act(K_OUT, 1, 0);
    for (int k = 0; k < 2; k++) begin
      act(K_ENT, 1, 0);
      act(K_DIG, 1, 7);
      act(k ? K_FN : K_ABT, 1, 3);
      chk("left keypad", 0, keypad_led);
      chk("restored", m_mag, disp_mag);
    end
    chk("func", 3, func);
    chk("forced park", 1, parked);
    act(K_OUT, 1, 0);
    chk("live", 0, parked | hi_res);
    act(K_NUL, 1, 0);
    chk("null", 1, null_on);
    chk("null disp", 0, disp_mag);
    chk("null set", 0, set_mag);
    act(K_NUL, 1, 0);
    chk("unnull", m_mag, disp_mag);
    act(K_OUT, 1, 0);
    chk("res", 1, hi_res);
    $display("test keypad done");
    act(K_FN, 1, 5);
    chk("zero charge", 1, zchg);
    op.tap(K_OUT, 1, 0);
    repeat (20) @(negedge clock_i);
    op.tap(K_OUT, 1, 0);
    chk("window", 0, parked);
    repeat (26) @(negedge clock_i);
    chk("window end", 0, parked);
    repeat (6) @(negedge clock_i);
    chk("reparked", 1, parked);
    $display("test charge done");
    act(K_FN, 1, 1);
    act(K_VIS, 1, 0);
    blinks(24, d);
    chk("cursor on", 1, d > 0);
    act(K_FN, 1, 1);
    repeat (20) @(negedge clock_i);
    blinks(16, d);
    chk("cursor off", 0, d);
    op.tap(K_L, 1, 0);
    blinks(8, d);
    chk("brief flash", 1, d > 0);
    repeat (8) @(negedge clock_i);
    blinks(16, d);
    chk("flash ends", 0, d);
    act(K_FN, 1, 0);
    pre = disp_mag;
    act(K_UP, 1, 0);
    chk("ohms fixed", pre, disp_mag);
    $display("test misc done");
    tally_and_finish();
  end
endmodule : fpve_top_tb
